// ---- design/vic_pkg.sv ----
// Notes on behaviour
// - Read-only enable mask, reset zero
// - Status bit 0 shows fast line active
// - Status bit 1 shows normal line active
// - Enable command sets mask bits written one
// - Disable command clears mask bits written one
// - Clear command clears pending bits written one
// - Set command forces pending bits written one
// - Any write to end command ends treatment
// - Spurious vector read/write, returned when spurious
// - Debug bit 0 enables protection mode
// - Debug bit 1 holds both lines inactive
// - Fast forcing enable, sources 1 to 31
// - Fast forcing disable, sources 1 to 31
package vic_pkg;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [8:0] OFS_PENDING     = 9'h10C;
  localparam logic [8:0] OFS_MASK        = 9'h110;
  localparam logic [8:0] OFS_LINE_STAT   = 9'h114;
  localparam logic [8:0] OFS_EN_CMD      = 9'h120;
  localparam logic [8:0] OFS_DIS_CMD     = 9'h124;
  localparam logic [8:0] OFS_CLR_CMD     = 9'h128;
  localparam logic [8:0] OFS_SET_CMD     = 9'h12C;
  localparam logic [8:0] OFS_EOT_CMD     = 9'h130;
  localparam logic [8:0] OFS_SPURIOUS    = 9'h134;
  localparam logic [8:0] OFS_DEBUG       = 9'h138;
  localparam logic [8:0] OFS_FF_EN       = 9'h140;
  localparam logic [8:0] OFS_FF_DIS      = 9'h144;
  localparam logic [8:0] OFS_FF_STAT     = 9'h148;
  localparam logic [8:0] OFS_NVEC        = 9'h100;
  localparam logic [8:0] OFS_FVEC        = 9'h104;
  localparam logic [8:0] OFS_EVT_STAT    = 9'h150;
  localparam logic [8:0] OFS_EVT_CLR     = 9'h154;
  localparam logic [8:0] OFS_EVT_EN      = 9'h158;

  // ***********************************************************
  // Fields and reset values
  // ***********************************************************
  localparam int         DBG_PROTECT_BIT = 0;
  localparam int         DBG_LMASK_BIT   = 1;
  localparam int         LS_FAST_BIT     = 0;
  localparam int         LS_NORM_BIT     = 1;
  localparam logic [31:0] FF_IMPL_MASK   = 32'hFFFF_FFFE;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam int         EVT_EOT_BIT     = 0;
  localparam int         EVT_SPUR_BIT    = 1;
  localparam int         EVT_WIDTH       = 2;

  typedef struct packed {
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vic_bus_type;

  typedef struct packed {
    logic [31:0]          mask;
    logic [31:0]          pending;
    logic [31:0]          ffe;
    logic [31:0]          spurious;
    logic [1:0]           debug;
    logic                 fast_line_n;
    logic                 norm_line_n;
    logic                 eot;
    logic [EVT_WIDTH-1:0] evt_stat;
    logic [EVT_WIDTH-1:0] evt_en;
    logic                 irq;
    logic [31:0]          rdata;
  } vic_state_type;

  // Request lines are active low, so they rest high
  localparam vic_state_type STATE_RST = '{fast_line_n : 1'b1,
                                          norm_line_n : 1'b1,
                                          default     : '0};

endpackage : vic_pkg

// ---- design/vic_top.sv ----
`timescale 1ns/1ps
module vic_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic [8:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [31:0] SRC_IN,
  output logic      [31:0] RDATA,
  output logic             FAST_REQUEST_LINE_N,
  output logic             NORMAL_REQUEST_LINE_N,
  output logic             END_OF_TREATMENT,
  output logic             PROTECTION_MODE,
  output logic             IRQ
);

  // ***********************************************************
  // Reset synchroniser
  // ***********************************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ***********************************************************
  // State
  // ***********************************************************
  vic_pkg::vic_bus_type   bus;
  vic_pkg::vic_state_type s_q;
  vic_pkg::vic_state_type s_d;

  assign bus.addr  = ADDR;
  assign bus.wdata = WDATA;
  assign bus.wr    = WR;
  assign bus.rd    = RD;

  function automatic logic wr_at(input vic_pkg::vic_bus_type b,
                                 input logic [8:0] ofs);
    wr_at = b.wr && (b.addr == ofs);
  endfunction : wr_at

  logic [31:0] active;
  logic [31:0] normal_src;
  logic        fast_req;
  logic        norm_req;
  logic        spur_n;
  logic        spur_f;

  always_comb begin
    s_d = s_q;
    // Pending captures high source levels; set beats clear
    s_d.pending = s_q.pending | SRC_IN;
    if (wr_at(bus, vic_pkg::OFS_CLR_CMD)) begin
      s_d.pending = s_d.pending & ~bus.wdata;
    end
    if (wr_at(bus, vic_pkg::OFS_SET_CMD)) begin
      s_d.pending = s_d.pending | bus.wdata;
    end
    if (wr_at(bus, vic_pkg::OFS_EN_CMD)) begin
      s_d.mask = s_d.mask | bus.wdata;
    end
    if (wr_at(bus, vic_pkg::OFS_DIS_CMD)) begin
      s_d.mask = s_d.mask & ~bus.wdata;
    end
    if (wr_at(bus, vic_pkg::OFS_FF_EN)) begin
      s_d.ffe = s_d.ffe | (bus.wdata & vic_pkg::FF_IMPL_MASK);
    end
    if (wr_at(bus, vic_pkg::OFS_FF_DIS)) begin
      s_d.ffe = s_d.ffe & ~(bus.wdata & vic_pkg::FF_IMPL_MASK);
    end
    if (wr_at(bus, vic_pkg::OFS_SPURIOUS)) begin
      s_d.spurious = bus.wdata;
    end
    if (wr_at(bus, vic_pkg::OFS_DEBUG)) begin
      s_d.debug = bus.wdata[1:0];
    end
    s_d.eot = wr_at(bus, vic_pkg::OFS_EOT_CMD);
    if (wr_at(bus, vic_pkg::OFS_EVT_EN)) begin
      s_d.evt_en = bus.wdata[vic_pkg::EVT_WIDTH-1:0];
    end

    active     = s_q.pending & s_q.mask;
    // Source 0 and forced sources go to the fast line
    normal_src = active & ~s_q.ffe & vic_pkg::FF_IMPL_MASK;
    fast_req   = active[0] | (|(active & s_q.ffe));
    norm_req   = |normal_src;
    s_d.fast_line_n = !(fast_req &&
                        !s_q.debug[vic_pkg::DBG_LMASK_BIT]);
    s_d.norm_line_n = !(norm_req &&
                        !s_q.debug[vic_pkg::DBG_LMASK_BIT]);

    spur_n = bus.rd && (bus.addr == vic_pkg::OFS_NVEC) && !norm_req;
    spur_f = bus.rd && (bus.addr == vic_pkg::OFS_FVEC) && !fast_req;

    // Sticky events; a new event wins over a clear
    if (wr_at(bus, vic_pkg::OFS_EVT_CLR)) begin
      s_d.evt_stat = s_q.evt_stat & ~bus.wdata[vic_pkg::EVT_WIDTH-1:0];
    end
    if (s_d.eot) begin
      s_d.evt_stat[vic_pkg::EVT_EOT_BIT] = 1'b1;
    end
    if (spur_n || spur_f) begin
      s_d.evt_stat[vic_pkg::EVT_SPUR_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.evt_stat & s_d.evt_en);

    s_d.rdata = vic_pkg::RST_WORD;
    if (bus.rd) begin
      case (bus.addr)
        vic_pkg::OFS_PENDING:   s_d.rdata = s_q.pending;
        vic_pkg::OFS_MASK:      s_d.rdata = s_q.mask;
        vic_pkg::OFS_LINE_STAT: begin
          s_d.rdata[vic_pkg::LS_FAST_BIT] = !s_q.fast_line_n;
          s_d.rdata[vic_pkg::LS_NORM_BIT] = !s_q.norm_line_n;
        end
        vic_pkg::OFS_NVEC:      s_d.rdata = norm_req ? 32'h0000_0000
                                                     : s_q.spurious;
        vic_pkg::OFS_FVEC:      s_d.rdata = fast_req ? 32'h0000_0000
                                                     : s_q.spurious;
        vic_pkg::OFS_SPURIOUS:  s_d.rdata = s_q.spurious;
        vic_pkg::OFS_DEBUG:     s_d.rdata = {30'h0, s_q.debug};
        vic_pkg::OFS_FF_STAT:   s_d.rdata = s_q.ffe;
        vic_pkg::OFS_EVT_STAT:  s_d.rdata = {30'h0, s_q.evt_stat};
        vic_pkg::OFS_EVT_EN:    s_d.rdata = {30'h0, s_q.evt_en};
        default:                s_d.rdata = vic_pkg::RST_WORD;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= vic_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign RDATA                 = s_q.rdata;
  assign FAST_REQUEST_LINE_N   = s_q.fast_line_n;
  assign NORMAL_REQUEST_LINE_N = s_q.norm_line_n;
  assign END_OF_TREATMENT      = s_q.eot;
  assign PROTECTION_MODE       = s_q.debug[vic_pkg::DBG_PROTECT_BIT];
  assign IRQ                   = s_q.irq;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  property p_mask_set;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_EN_CMD) |=>
      ((s_q.mask & $past(WDATA)) == $past(WDATA));
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("enable command did not set mask");

  property p_mask_clr;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_DIS_CMD) |=>
      ((s_q.mask & $past(WDATA)) == 32'h0000_0000);
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("disable command did not clear mask");

  property p_mask_hold;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    !(WR && (ADDR == vic_pkg::OFS_EN_CMD || ADDR == vic_pkg::OFS_DIS_CMD))
      |=> $stable(s_q.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a command");

  property p_pend_set;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_SET_CMD) |=>
      ((s_q.pending & $past(WDATA)) == $past(WDATA));
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("set command did not force pending");

  property p_pend_clr;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_CLR_CMD && SRC_IN == 32'h0000_0000) |=>
      ((s_q.pending & $past(WDATA)) == 32'h0000_0000);
  endproperty
  a_pend_clr: assert property (p_pend_clr)
    else $error("clear command did not clear pending");

  property p_eot;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_EOT_CMD) |=> END_OF_TREATMENT;
  endproperty
  a_eot: assert property (p_eot)
    else $error("end of treatment pulse wrong");

  property p_global_line_mask;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    s_q.debug[vic_pkg::DBG_LMASK_BIT] |=>
      (FAST_REQUEST_LINE_N && NORMAL_REQUEST_LINE_N);
  endproperty
  a_global_line_mask: assert property (p_global_line_mask)
    else $error("lines active under global mask");

  property p_line_stat;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_LINE_STAT) |=>
      (RDATA[1:0] == {~$past(NORMAL_REQUEST_LINE_N),
                      ~$past(FAST_REQUEST_LINE_N)});
  endproperty
  a_line_stat: assert property (p_line_stat)
    else $error("line status read wrong");

  property p_ff_bit0;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_FF_STAT) |=> !RDATA[0];
  endproperty
  a_ff_bit0: assert property (p_ff_bit0)
    else $error("fast forcing bit 0 set");

  property p_protection_mode_enable;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_DEBUG) |=>
      (PROTECTION_MODE == $past(WDATA[0]));
  endproperty
  a_protection_mode_enable: assert property (p_protection_mode_enable)
    else $error("protection mode not written");

  property p_spur;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_NVEC && !norm_req) |=>
      (RDATA == s_q.spurious);
  endproperty
  a_spur: assert property (p_spur)
    else $error("spurious vector not returned");

  property p_fvec_spur;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_FVEC && !fast_req) |=>
      (RDATA == s_q.spurious);
  endproperty
  a_fvec_spur: assert property (p_fvec_spur)
    else $error("spurious fast vector not returned");

  property p_eot_idle;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    !(WR && ADDR == vic_pkg::OFS_EOT_CMD) |=> !END_OF_TREATMENT;
  endproperty
  a_eot_idle: assert property (p_eot_idle)
    else $error("end of treatment without a write");

  property p_ff_set;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_FF_EN) |=>
      ((s_q.ffe & $past(WDATA) & vic_pkg::FF_IMPL_MASK) ==
       ($past(WDATA) & vic_pkg::FF_IMPL_MASK));
  endproperty
  a_ff_set: assert property (p_ff_set)
    else $error("fast forcing enable not applied");

  property p_ff_clr;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (WR && ADDR == vic_pkg::OFS_FF_DIS) |=>
      ((s_q.ffe & $past(WDATA)) == 32'h0000_0000);
  endproperty
  a_ff_clr: assert property (p_ff_clr)
    else $error("fast forcing disable not applied");

  property p_mask_read;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_MASK) |=>
      (RDATA == $past(s_q.mask));
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read wrong");

  property p_dbg_read;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (RD && ADDR == vic_pkg::OFS_DEBUG) |=>
      (RDATA == {30'h0, $past(s_q.debug)});
  endproperty
  a_dbg_read: assert property (p_dbg_read)
    else $error("debug control read wrong");

  property p_protection_mode_enable_hold;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    !(WR && ADDR == vic_pkg::OFS_DEBUG) |=> $stable(PROTECTION_MODE);
  endproperty
  a_protection_mode_enable_hold: assert property (p_protection_mode_enable_hold)
    else $error("protection mode changed without a write");

  property p_fast_on;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (fast_req && !s_q.debug[vic_pkg::DBG_LMASK_BIT]) |=>
      !FAST_REQUEST_LINE_N;
  endproperty
  a_fast_on: assert property (p_fast_on)
    else $error("fast line not driven for a fast request");

  property p_fast_off;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    !fast_req |=> FAST_REQUEST_LINE_N;
  endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("fast line active without a request");

  property p_norm_on;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (norm_req && !s_q.debug[vic_pkg::DBG_LMASK_BIT]) |=>
      !NORMAL_REQUEST_LINE_N;
  endproperty
  a_norm_on: assert property (p_norm_on)
    else $error("normal line not driven for a request");

  property p_norm_off;
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    !norm_req |=> NORMAL_REQUEST_LINE_N;
  endproperty
  a_norm_off: assert property (p_norm_off)
    else $error("normal line active without a request");

  // ***********************************************************
  // Cover points
  // ***********************************************************

  c_fast: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    !FAST_REQUEST_LINE_N);
  c_norm: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    !NORMAL_REQUEST_LINE_N);
  c_eot: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    END_OF_TREATMENT);
  c_irq: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q) IRQ);
  c_spur: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RD && ADDR == vic_pkg::OFS_NVEC && !norm_req);

endmodule : vic_top

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [8:0]  addr    = 9'h000;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] src_in  = 32'h0;
  logic [31:0] rdata;
  logic        fast_n, norm_n, eot, protect, irq, fast_act, norm_act;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [31:0] rnd = 32'h0000_0022;
  logic [31:0] mask_m = 32'h0;
  logic [31:0] pend_m = 32'h0;
  logic [31:0] ff_m = 32'h0;
  logic [31:0] r, e;

  always #5 sys_clk = ~sys_clk;

  vic_top DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .SRC_IN(src_in), .RDATA(rdata),
    .FAST_REQUEST_LINE_N(fast_n), .NORMAL_REQUEST_LINE_N(norm_n),
    .END_OF_TREATMENT(eot), .PROTECTION_MODE(protect), .IRQ(irq));

  vic_core_model core (.clk(sys_clk), .rst_n(rst_n), .fast_n(fast_n),
    .norm_n(norm_n), .fast_act(fast_act), .norm_act(norm_act));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Expected line status: bit 0 fast, bit 1 normal
  function automatic logic [31:0] line_exp(input logic [31:0] m, p, f,
                                           input logic gm);
    logic [31:0] act;
    act = m & p;
    if (gm)
      return 32'h0;
    return {30'h0, |(act & ~f & 32'hFFFF_FFFE), act[0] | (|(act & f))};
  endfunction : line_exp

  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic final_report;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    step(4);
    `CHK({fast_n, norm_n}, 2'b11)
    rd_reg(vic_pkg::OFS_MASK, r);
    `CHK(r, 32'h0)
    rd_reg(vic_pkg::OFS_SPURIOUS, r);
    `CHK(r, 32'h0)
    rd_reg(vic_pkg::OFS_DEBUG, r);
    `CHK(r, 32'h0)
    rnd = lfsr_next(rnd);
    @(posedge sys_clk);
    src_in <= rnd;
    @(posedge sys_clk);
    src_in <= 32'h0;
    pend_m = rnd;
    rd_reg(vic_pkg::OFS_PENDING, r);
    `CHK(r, pend_m)
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_EN_CMD, rnd);
      mask_m = mask_m | rnd;
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_DIS_CMD, rnd);
      mask_m = mask_m & ~rnd;
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_SET_CMD, rnd);
      pend_m = pend_m | rnd;
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_CLR_CMD, rnd);
      pend_m = pend_m & ~rnd;
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_FF_EN, rnd);
      ff_m = ff_m | (rnd & vic_pkg::FF_IMPL_MASK);
      rnd = lfsr_next(rnd);
      wr_reg(vic_pkg::OFS_FF_DIS, rnd);
      ff_m = ff_m & ~rnd;
      rd_reg(vic_pkg::OFS_MASK, r);
      `CHK(r, mask_m)
      rd_reg(vic_pkg::OFS_PENDING, r);
      `CHK(r, pend_m)
      rd_reg(vic_pkg::OFS_FF_STAT, r);
      `CHK(r, ff_m)
      step(3);
      e = line_exp(mask_m, pend_m, ff_m, 1'b0);
      rd_reg(vic_pkg::OFS_LINE_STAT, r);
      `CHK(r, e)
      `CHK({norm_act, fast_act}, e[1:0])
    end
    // Make both lines active so that the global mask has work to do
    wr_reg(vic_pkg::OFS_EN_CMD, 32'h0000_0005);
    wr_reg(vic_pkg::OFS_SET_CMD, 32'h0000_0005);
    wr_reg(vic_pkg::OFS_FF_DIS, 32'h0000_0004);
    mask_m = mask_m | 32'h0000_0005;
    pend_m = pend_m | 32'h0000_0005;
    ff_m   = ff_m & ~32'h0000_0004;
    step(3);
    `CHK({fast_n, norm_n}, 2'b00)
    wr_reg(vic_pkg::OFS_DEBUG, 32'h0000_0002);
    step(3);
    rd_reg(vic_pkg::OFS_LINE_STAT, r);
    `CHK(r, 32'h0)
    `CHK({fast_n, norm_n}, 2'b11)
    wr_reg(vic_pkg::OFS_DEBUG, 32'h0000_0001);
    step(3);
    `CHK(protect, 1'b1)
    rd_reg(vic_pkg::OFS_LINE_STAT, r);
    `CHK(r, line_exp(mask_m, pend_m, ff_m, 1'b0))
    wr_reg(vic_pkg::OFS_EVT_EN, 32'h0000_0001);
    wr_reg(vic_pkg::OFS_EOT_CMD, rnd);
    #1;
    `CHK(eot, 1'b1)
    step(1);
    `CHK(eot, 1'b0)
    step(1);
    `CHK(irq, 1'b1)
    wr_reg(vic_pkg::OFS_EVT_EN, 32'h0);
    step(2);
    `CHK(irq, 1'b0)
    wr_reg(vic_pkg::OFS_EVT_CLR, 32'h0000_0003);
    wr_reg(vic_pkg::OFS_EVT_EN, 32'h0000_0001);
    step(2);
    `CHK(irq, 1'b0)
    rnd = lfsr_next(rnd);
    wr_reg(vic_pkg::OFS_SPURIOUS, rnd);
    wr_reg(vic_pkg::OFS_DIS_CMD, 32'hFFFF_FFFF);
    wr_reg(vic_pkg::OFS_CLR_CMD, 32'hFFFF_FFFF);
    wr_reg(vic_pkg::OFS_MASK, 32'hFFFF_FFFF);
    step(3);
    rd_reg(vic_pkg::OFS_MASK, r);
    `CHK(r, 32'h0)
    rd_reg(vic_pkg::OFS_NVEC, r);
    `CHK(r, rnd)
    rd_reg(vic_pkg::OFS_FVEC, r);
    `CHK(r, rnd)
    rd_reg(9'h1FC, r);
    `CHK(r, 32'h0)
    final_report();
  end
endmodule : tb

// ---- verif/vic_core_model.sv ----
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fast_n,
  input  wire logic norm_n,
  output logic      fast_act,
  output logic      norm_act
);
  // Core samples its active-low request lines on each rising clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_act <= 1'b0;
      norm_act <= 1'b0;
    end else begin
      fast_act <= ~fast_n;
      norm_act <= ~norm_n;
    end
  end
endmodule : vic_core_model
